// [status_regs.svh]
// Purpose: Constants of the instrument status reporting block.
// Assumes: Included by the package, status_group and the top module by bare name.
// Notes: Selector codes address the registers over the query port.
// Operation
// - Bit 3 zero when no error.
// - Status byte bit 4 flags waiting reply.
// - Four condition registers, 16 and 8 bits.
// - Event register latches events, read clears all but rises in the read cycle.
// - Enable register gates events into summary.
// - Only zero-to-one condition transitions set events.
// - Enabled questionable event asserts status bit 3.
// - Bit 6 is OR of enabled other bits.
// - Bit 6 one drives the service request line.
// - Non-empty error queue sets service request bit 3.
// - Operation bits 0-4, 7, 13, 15 read zero.
// - Operation bit 5 trigger wait, held while low.
// - Operation bit 6 set while transient armed.
// - Operation bits 8 and 10: CV, CC.
// - Operation bits 9, 12 events only, unreadable.
// - Operation bit 11 sample done, 14 list running.
// - Questionable bits 0 and 1 show mode.
// - Questionable bits 3 thermal, 6 slave fault.
// - Bits 12, 13 protection; external reference sets both.
// - Questionable bit 14 set while sinking.
// - Questionable bits 2, 4, 5, 7-11, 15 zero.
`ifndef STATUS_REGS_SVH
`define STATUS_REGS_SVH

`define SEL_OPERATION_STATUS_COND 4'h0
`define SEL_OPERATION_STATUS_EVT 4'h1
`define SEL_OPERATION_STATUS_EN 4'h2
`define SEL_QUESTIONABLE_STATUS_COND 4'h3
`define SEL_QUESTIONABLE_STATUS_EVT 4'h4
`define SEL_QUESTIONABLE_STATUS_EN 4'h5
`define SEL_STD_COND 4'h6
`define SEL_STD_EVT 4'h7
`define SEL_STD_EN 4'h8
`define SEL_SRQ_COND 4'h9
`define SEL_SRQ_EVT 4'ha
`define SEL_SRQ_EN 4'hb

`define OPERATION_STATUS_WAIT_TRIG 5
`define OPERATION_STATUS_ARMED 6
`define OPERATION_STATUS_CV 8
`define OPERATION_STATUS_TRAN_DONE 9
`define OPERATION_STATUS_CC 10
`define OPERATION_STATUS_SAMPLE 11
`define OPERATION_STATUS_LIST_DONE 12
`define OPERATION_STATUS_LIST_RUN 14
`define OPERATION_STATUS_READ_MASK 16'h4d60

`define QUESTIONABLE_STATUS_CURR_MODE 0
`define QUESTIONABLE_STATUS_VOLT_MODE 1
`define QUESTIONABLE_STATUS_THERMAL 3
`define QUESTIONABLE_STATUS_SLAVE 6
`define QUESTIONABLE_STATUS_VPROT 12
`define QUESTIONABLE_STATUS_CPROT 13
`define QUESTIONABLE_STATUS_SINK 14
`define QUESTIONABLE_STATUS_READ_MASK 16'h704b

`define STB_QUESTIONABLE_STATUS 3
`define STB_MSG 4
`define STB_STD 5
`define STB_RQS 6
`define STB_OPERATION_STATUS 7

`define EN16_RESET 16'h0000
`define EN8_RESET 8'h00
`define DATA16_RESET 16'h0000
`define DATA8_RESET 8'h00

`endif

// [status_pkg.sv]
// Purpose: Types shared by the status reporting modules.
// Assumes: Constants come from the guarded header.
// Notes: Selectors are fixed by the header codes.
`include "status_regs.svh"
package status_pkg;

  typedef enum logic [3:0] {
    SEL_OPERATION_STATUS_COND = `SEL_OPERATION_STATUS_COND,
    SEL_OPERATION_STATUS_EVT = `SEL_OPERATION_STATUS_EVT,
    SEL_OPERATION_STATUS_EN = `SEL_OPERATION_STATUS_EN,
    SEL_QUESTIONABLE_STATUS_COND = `SEL_QUESTIONABLE_STATUS_COND,
    SEL_QUESTIONABLE_STATUS_EVT = `SEL_QUESTIONABLE_STATUS_EVT,
    SEL_QUESTIONABLE_STATUS_EN = `SEL_QUESTIONABLE_STATUS_EN,
    SEL_STD_COND = `SEL_STD_COND,
    SEL_STD_EVT = `SEL_STD_EVT,
    SEL_STD_EN = `SEL_STD_EN,
    SEL_SRQ_COND = `SEL_SRQ_COND,
    SEL_SRQ_EVT = `SEL_SRQ_EVT,
    SEL_SRQ_EN = `SEL_SRQ_EN
  } reg_sel_type;

  typedef struct packed {
    logic trigEnabled;
    logic trigExternal;
    logic trigInput;
    logic transientArmed;
    logic constVoltage;
    logic transientDone;
    logic constCurrent;
    logic sampleDone;
    logic listDone;
    logic listRunning;
  } operation_in_type;

  typedef struct packed {
    logic currentMode;
    logic voltageMode;
    logic thermalErr;
    logic slaveFault;
    logic voltProtErr;
    logic currProtErr;
    logic extRefEnabled;
    logic sinking;
  } questionable_in_type;

  typedef struct packed {
    logic rd;
    logic wr;
    reg_sel_type sel;
    logic [15:0] wdata;
  } reg_req_type;

endpackage

// [status_group.sv]
// Purpose: One condition register group with event latch and enable.
// Assumes: Reset is already synchronised to mclk.
// Notes: Summary is combinational from current event and enable contents.
`timescale 1ns/1ps
`include "status_regs.svh"
module status_group #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstSync_n,
  // Condition and access.
  input wire logic [W-1:0] condIn,
  input wire logic readEvt,
  input wire logic wrEn,
  input wire logic [W-1:0] enIn,
  // State out.
  output logic [W-1:0] evtOut,
  output logic [W-1:0] enOut,
  output logic summary
);
  logic [W-1:0] cond_q;
  logic [W-1:0] cond_d;
  logic [W-1:0] evt_q;
  logic [W-1:0] evt_d;
  logic [W-1:0] en_q;
  logic [W-1:0] en_d;
  logic [W-1:0] rise;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_edge
      assign rise[i] = condIn[i] & ~cond_q[i];
    end
  endgenerate

  always_comb begin
    cond_d = condIn;
    evt_d = (readEvt ? '0 : evt_q) | rise;
    en_d = wrEn ? enIn : en_q;
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cond_q <= '0;
      evt_q <= '0;
      en_q <= '0;
    end else begin
      cond_q <= cond_d;
      evt_q <= evt_d;
      en_q <= en_d;
    end
  end

  assign evtOut = evt_q;
  assign enOut = en_q;
  assign summary = |(evt_q & en_q);
endmodule

// [trigger_wait_hold.sv]
// Purpose: Produces the trigger wait flag with external input hold.
// Assumes: Trigger input is synchronous to mclk.
// Notes: The hold starts when the input goes low with external source.
`timescale 1ns/1ps
module trigger_wait_hold (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstSync_n,
  // Trigger state.
  input wire logic trigEnabled,
  input wire logic trigExternal,
  input wire logic trigInput,
  // Flag out.
  output logic triggerWaitFlag
);
  logic hold_q;
  logic hold_d;

  always_comb begin
    hold_d = hold_q;
    if (trigInput) begin
      hold_d = 1'b0;
    end else if (trigExternal && trigEnabled) begin
      hold_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
    end
  end

  assign triggerWaitFlag = trigEnabled | hold_q;
endmodule

// [instrument_status_reporting.sv]
// Purpose: Status reporting of the instrument: four register groups and request line.
// Assumes: Command parser drives the register request port; inputs are synchronous.
// Notes: Event registers clear on the cycle their read is taken.
`timescale 1ns/1ps
`include "status_regs.svh"
module instrument_status_reporting
  import status_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Instrument state.
  input wire operation_in_type operationIn,
  input wire questionable_in_type questionableIn,
  input wire logic [7:0] stdEventIn,
  input wire logic errQueueNotEmpty,
  input wire logic replyWaiting,
  // Register request from the parser.
  input wire reg_req_type regReq,
  // Read answer.
  output logic [15:0] regRdata_q,
  output logic regRvalid_q,
  // Status byte and service request.
  output logic [7:0] statusByte_q,
  output logic srqAssert_q
);
  logic rstMeta_q;
  logic rstSync_n;
  logic waitFlag;
  logic [15:0] operCond;
  logic [15:0] operEvtSrc;
  logic [15:0] operRead;
  logic [15:0] quesCond;
  logic [15:0] quesRead;
  logic [7:0] stbCond;
  logic [15:0] operEvt;
  logic [15:0] operEn;
  logic [15:0] quesEvt;
  logic [15:0] quesEn;
  logic [7:0] stdEvt;
  logic [7:0] stdEn;
  logic [7:0] srqEvt;
  logic [7:0] srqEn;
  logic operSum;
  logic quesSum;
  logic stdSum;
  logic rdOperEvt;
  logic rdQuesEvt;
  logic rdStdEvt;
  logic rdSrqEvt;
  logic wrOperEn;
  logic wrQuesEn;
  logic wrStdEn;
  logic wrSrqEn;
  logic protAny;
  logic rqs;
  logic [15:0] rdata_d;
  logic rvalid_d;
  logic [7:0] stb_d;
  logic srq_d;
  logic [15:0] stdCondWide;

  // Reset release through two flip-flops.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_n <= rstMeta_q;
    end
  end

  function automatic logic isSel(input reg_req_type r, input reg_sel_type s);
    isSel = (r.sel == s);
  endfunction

  function automatic logic [15:0] widenByte(input logic [7:0] b);
    widenByte = {8'h00, b};
  endfunction

  // Register port strobes, one per event read and enable write.
  always_comb begin
    rdOperEvt = regReq.rd && isSel(regReq, SEL_OPERATION_STATUS_EVT);
    rdQuesEvt = regReq.rd && isSel(regReq, SEL_QUESTIONABLE_STATUS_EVT);
    rdStdEvt = regReq.rd && isSel(regReq, SEL_STD_EVT);
    rdSrqEvt = regReq.rd && isSel(regReq, SEL_SRQ_EVT);
    wrOperEn = regReq.wr && isSel(regReq, SEL_OPERATION_STATUS_EN);
    wrQuesEn = regReq.wr && isSel(regReq, SEL_QUESTIONABLE_STATUS_EN);
    wrStdEn = regReq.wr && isSel(regReq, SEL_STD_EN);
    wrSrqEn = regReq.wr && isSel(regReq, SEL_SRQ_EN);
  end

  trigger_wait_hold u_trig (
    .mclk(mclk),
    .rstSync_n(rstSync_n),
    .trigEnabled(operationIn.trigEnabled),
    .trigExternal(operationIn.trigExternal),
    .trigInput(operationIn.trigInput),
    .triggerWaitFlag(waitFlag)
  );

  // Operation condition; transient and list done bits feed events but read as zero.
  always_comb begin
    operEvtSrc = 16'h0000;
    operEvtSrc[`OPERATION_STATUS_WAIT_TRIG] = waitFlag;
    operEvtSrc[`OPERATION_STATUS_ARMED] = operationIn.transientArmed;
    operEvtSrc[`OPERATION_STATUS_CV] = operationIn.constVoltage;
    operEvtSrc[`OPERATION_STATUS_TRAN_DONE] = operationIn.transientDone;
    operEvtSrc[`OPERATION_STATUS_CC] = operationIn.constCurrent;
    operEvtSrc[`OPERATION_STATUS_SAMPLE] = operationIn.sampleDone;
    operEvtSrc[`OPERATION_STATUS_LIST_DONE] = operationIn.listDone;
    operEvtSrc[`OPERATION_STATUS_LIST_RUN] = operationIn.listRunning;
    operCond = operEvtSrc;
    operRead = operCond & `OPERATION_STATUS_READ_MASK;
  end

  // Questionable condition.
  assign protAny = questionableIn.voltProtErr | questionableIn.currProtErr;

  always_comb begin
    quesCond = 16'h0000;
    quesCond[`QUESTIONABLE_STATUS_CURR_MODE] = questionableIn.currentMode;
    quesCond[`QUESTIONABLE_STATUS_VOLT_MODE] = questionableIn.voltageMode;
    quesCond[`QUESTIONABLE_STATUS_THERMAL] = questionableIn.thermalErr;
    quesCond[`QUESTIONABLE_STATUS_SLAVE] = questionableIn.slaveFault;
    quesCond[`QUESTIONABLE_STATUS_SINK] = questionableIn.sinking;
    if (questionableIn.extRefEnabled) begin
      quesCond[`QUESTIONABLE_STATUS_VPROT] = protAny;
      quesCond[`QUESTIONABLE_STATUS_CPROT] = protAny;
    end else begin
      quesCond[`QUESTIONABLE_STATUS_VPROT] = questionableIn.voltProtErr;
      quesCond[`QUESTIONABLE_STATUS_CPROT] = questionableIn.currProtErr;
    end
    quesRead = quesCond & `QUESTIONABLE_STATUS_READ_MASK;
  end

  // Four register groups of 16 and 8 bits.
  status_group #(.W(16)) u_operation_status (
    .mclk(mclk),
    .rstSync_n(rstSync_n),
    .condIn(operEvtSrc),
    .readEvt(rdOperEvt),
    .wrEn(wrOperEn),
    .enIn(regReq.wdata),
    .evtOut(operEvt),
    .enOut(operEn),
    .summary(operSum)
  );

  status_group #(.W(16)) u_questionable_status (
    .mclk(mclk),
    .rstSync_n(rstSync_n),
    .condIn(quesCond),
    .readEvt(rdQuesEvt),
    .wrEn(wrQuesEn),
    .enIn(regReq.wdata),
    .evtOut(quesEvt),
    .enOut(quesEn),
    .summary(quesSum)
  );

  status_group #(.W(8)) u_std (
    .mclk(mclk),
    .rstSync_n(rstSync_n),
    .condIn(stdEventIn),
    .readEvt(rdStdEvt),
    .wrEn(wrStdEn),
    .enIn(regReq.wdata[7:0]),
    .evtOut(stdEvt),
    .enOut(stdEn),
    .summary(stdSum)
  );

  // Status byte from current summaries, recomputed every cycle.
  always_comb begin
    stbCond = 8'h00;
    stbCond[`STB_QUESTIONABLE_STATUS] = quesSum | errQueueNotEmpty;
    stbCond[`STB_MSG] = replyWaiting;
    stbCond[`STB_STD] = stdSum;
    stbCond[`STB_OPERATION_STATUS] = operSum;
    rqs = 1'b0;
    for (int b = 0; b < 8; b++) begin
      if (b != `STB_RQS) begin
        rqs = rqs | (stbCond[b] & srqEn[b]);
      end
    end
    stbCond[`STB_RQS] = rqs;
  end

  status_group #(.W(8)) u_srq (
    .mclk(mclk),
    .rstSync_n(rstSync_n),
    .condIn(stbCond),
    .readEvt(rdSrqEvt),
    .wrEn(wrSrqEn),
    .enIn(regReq.wdata[7:0]),
    .evtOut(srqEvt),
    .enOut(srqEn),
    .summary()
  );

  assign stdCondWide = widenByte(stdEventIn);

  // Read mux and output registers.
  always_comb begin
    rdata_d = regRdata_q;
    rvalid_d = regReq.rd;
    stb_d = stbCond;
    srq_d = stbCond[`STB_RQS];
    if (regReq.rd) begin
      case (regReq.sel)
        SEL_OPERATION_STATUS_COND: rdata_d = operRead;
        SEL_OPERATION_STATUS_EVT: rdata_d = operEvt;
        SEL_OPERATION_STATUS_EN: rdata_d = operEn;
        SEL_QUESTIONABLE_STATUS_COND: rdata_d = quesRead;
        SEL_QUESTIONABLE_STATUS_EVT: rdata_d = quesEvt;
        SEL_QUESTIONABLE_STATUS_EN: rdata_d = quesEn;
        SEL_STD_COND: rdata_d = stdCondWide;
        SEL_STD_EVT: rdata_d = widenByte(stdEvt);
        SEL_STD_EN: rdata_d = widenByte(stdEn);
        SEL_SRQ_COND: rdata_d = widenByte(stbCond);
        SEL_SRQ_EVT: rdata_d = widenByte(srqEvt);
        SEL_SRQ_EN: rdata_d = widenByte(srqEn);
        default: rdata_d = `DATA16_RESET;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      regRdata_q <= `DATA16_RESET;
      regRvalid_q <= 1'b0;
      statusByte_q <= `DATA8_RESET;
      srqAssert_q <= 1'b0;
    end else begin
      regRdata_q <= rdata_d;
      regRvalid_q <= rvalid_d;
      statusByte_q <= stb_d;
      srqAssert_q <= srq_d;
    end
  end
endmodule

// [status_assertions.sv]
// Purpose: Port checks of the status reporting block.
// Assumes: No request before internal reset ends.
// Notes: Bound to the top module below.
`timescale 1ns/1ps
module status_assertions
  import status_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Inputs.
  input wire logic errQueueNotEmpty,
  input wire logic replyWaiting,
  input wire reg_req_type regReq,
  // Outputs.
  input wire logic [15:0] regRdata_q,
  input wire logic regRvalid_q,
  input wire logic [7:0] statusByte_q,
  input wire logic srqAssert_q
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  read_answer_a: assert property (regReq.rd |=> regRvalid_q)
    else $error("Read got no answer.");
  quiet_answer_a: assert property (!regReq.rd |=> !regRvalid_q)
    else $error("Answer without read.");
  srq_line_a: assert property (srqAssert_q == statusByte_q[6])
    else $error("Request line differs from bit 6.");
  reply_bit_a: assert property (replyWaiting |=> statusByte_q[4])
    else $error("Reply bit not set.");
  queue_bit_a: assert property (errQueueNotEmpty |=> statusByte_q[3])
    else $error("Queue bit not set.");
  operation_status_zero_a: assert property (regReq.rd && regReq.sel == SEL_OPERATION_STATUS_COND
    |=> (regRdata_q & 16'hb29f) == 16'h0000) else $error("Unused operation bit set.");
  questionable_status_zero_a: assert property (regReq.rd && regReq.sel == SEL_QUESTIONABLE_STATUS_COND
    |=> (regRdata_q & 16'h8fb4) == 16'h0000) else $error("Unused questionable bit set.");
  byte_width_a: assert property (regReq.rd && regReq.sel >= SEL_STD_COND
    |=> regRdata_q[15:8] == 8'h00) else $error("Upper byte set.");
endmodule

bind instrument_status_reporting status_assertions chk (.mclk(mclk), .arst_n(arst_n),
  .errQueueNotEmpty(errQueueNotEmpty), .replyWaiting(replyWaiting), .regReq(regReq),
  .regRdata_q(regRdata_q), .regRvalid_q(regRvalid_q), .statusByte_q(statusByte_q),
  .srqAssert_q(srqAssert_q));

// [status_host.sv]
// Purpose: Host controller model on the register request port.
// Assumes: Called one step after a rising edge.
// Notes: A request is held over its take edge, then dropped.
`timescale 1ns/1ps
module status_host
  import status_pkg::*;
(
  // Clock.
  input wire logic mclk,
  // Register port.
  output reg_req_type regReq,
  input wire logic [15:0] regRdata_q,
  input wire logic regRvalid_q
);
  initial regReq = '0;

  // Reads one register; data counts only when flagged valid.
  // An idle edge follows each request so strobes never toggle twice at once.
  task automatic rd(input reg_sel_type s, output logic [15:0] d);
    regReq.sel = s;
    regReq.rd = 1'b1;
    @(posedge mclk);
    #1;
    d = (regRvalid_q === 1'b1) ? regRdata_q : 16'hxxxx;
    regReq.rd = 1'b0;
    @(posedge mclk);
    #1;
  endtask

  // Writes one register; data is scrambled once released.
  task automatic wr(input reg_sel_type s, input logic [15:0] v);
    regReq.sel = s;
    regReq.wdata = v;
    regReq.wr = 1'b1;
    @(posedge mclk);
    #1 regReq.wr = 1'b0;
    regReq.wdata = ~v;
    @(posedge mclk);
    #1;
  endtask
endmodule

// [instrument_status_reporting_test.sv]
// Purpose: Self-checking bench of the status reporting block.
// Assumes: The host model drives the register port.
// Notes: Random operation and questionable reads are checked against the model functions here.
`timescale 1ns/1ps
module instrument_status_reporting_test
  import status_pkg::*;
;
  logic mclk;
  logic arst_n;
  operation_in_type operationIn;
  questionable_in_type questionableIn;
  logic [7:0] stdEventIn;
  logic errQueueNotEmpty;
  logic replyWaiting;
  reg_req_type regReq;
  logic [15:0] regRdata_q;
  logic regRvalid_q;
  logic [7:0] statusByte_q;
  logic srqAssert_q;
  int n_errors = 0;
  int n_tests = 0;
  int unsigned seed = 30012;

  instrument_status_reporting dut (.mclk(mclk), .arst_n(arst_n), .operationIn(operationIn),
    .questionableIn(questionableIn), .stdEventIn(stdEventIn),
    .errQueueNotEmpty(errQueueNotEmpty), .replyWaiting(replyWaiting), .regReq(regReq),
    .regRdata_q(regRdata_q), .regRvalid_q(regRvalid_q), .statusByte_q(statusByte_q),
    .srqAssert_q(srqAssert_q));
  status_host host (.mclk(mclk), .regReq(regReq), .regRdata_q(regRdata_q),
    .regRvalid_q(regRvalid_q));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  function int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Operation condition with an internal trigger source.
  function automatic logic [15:0] operExp(operation_in_type o);
    return {1'b0, o.listRunning, 2'b00, o.sampleDone, o.constCurrent, 1'b0,
      o.constVoltage, 1'b0, o.transientArmed, o.trigEnabled, 5'h00};
  endfunction

  function automatic logic [15:0] quesExp(questionable_in_type q);
    logic p;
    p = q.extRefEnabled & (q.voltProtErr | q.currProtErr);
    return {1'b0, q.sinking, q.currProtErr | p, q.voltProtErr | p, 5'h00, q.slaveFault,
      2'b00, q.thermalErr, 1'b0, q.voltageMode, q.currentMode};
  endfunction

  task automatic check(input string w, input logic [15:0] seen, input logic [15:0] e);
    n_tests++;
    if (seen !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", w, e, seen);
    end
  endtask

  task automatic rc(input string w, input reg_sel_type s, input logic [15:0] e);
    logic [15:0] d;
    host.rd(s, d);
    check(w, d, e);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    logic [15:0] d;
    {operationIn, questionableIn, stdEventIn, errQueueNotEmpty, replyWaiting} = '0;
    arst_n = 1'b0;
    tick(8);
    arst_n = 1'b1;
    tick(3);
    for (int i = 0; i < 16; i++) rc("reset", reg_sel_type'(4'(i)), 16'h0000);
    for (int i = 0; i < 8; i++) begin
      operationIn = 10'(rnd()) & 10'h2ff;
      questionableIn = 8'(rnd());
      stdEventIn = 8'(rnd());
      tick(2);
      rc("operation_status", SEL_OPERATION_STATUS_COND, operExp(operationIn));
      rc("questionable_status", SEL_QUESTIONABLE_STATUS_COND, quesExp(questionableIn));
      rc("std", SEL_STD_COND, {8'h00, stdEventIn});
    end
    {operationIn, questionableIn, stdEventIn} = '0;
    tick(2);
    for (int i = 1; i < 12; i += 3) host.rd(reg_sel_type'(4'(i)), d);
    operationIn.transientDone = 1'b1;
    operationIn.listDone = 1'b1;
    tick(2);
    rc("done cond", SEL_OPERATION_STATUS_COND, 16'h0000);
    rc("done evt", SEL_OPERATION_STATUS_EVT, 16'h1200);
    rc("done level", SEL_OPERATION_STATUS_EVT, 16'h0000);
    operationIn = '0;
    operationIn.trigEnabled = 1'b1;
    operationIn.trigExternal = 1'b1;
    operationIn.trigInput = 1'b1;
    tick(2);
    operationIn.trigInput = 1'b0;
    tick(2);
    operationIn.trigEnabled = 1'b0;
    tick(2);
    rc("trig hold", SEL_OPERATION_STATUS_COND, 16'h0020);
    operationIn.trigInput = 1'b1;
    tick(2);
    rc("trig free", SEL_OPERATION_STATUS_COND, 16'h0000);
    questionableIn.thermalErr = 1'b1;
    tick(2);
    check("byte masked", 16'(statusByte_q), 16'h0000);
    host.wr(SEL_QUESTIONABLE_STATUS_EN, 16'h0008);
    tick(2);
    check("byte questionable_status", 16'(statusByte_q), 16'h0008);
    host.wr(SEL_SRQ_EN, 16'h0008);
    tick(2);
    check("byte srq", 16'(statusByte_q), 16'h0048);
    check("srq line", 16'(srqAssert_q), 16'h0001);
    rc("questionable_status evt", SEL_QUESTIONABLE_STATUS_EVT, 16'h0008);
    rc("questionable_status level", SEL_QUESTIONABLE_STATUS_EVT, 16'h0000);
    tick(2);
    check("byte clear", 16'(statusByte_q), 16'h0000);
    rc("questionable_status en", SEL_QUESTIONABLE_STATUS_EN, 16'h0008);
    errQueueNotEmpty = 1'b1;
    replyWaiting = 1'b1;
    tick(2);
    check("byte queue", 16'(statusByte_q), 16'h0058);
    host.wr(SEL_OPERATION_STATUS_EN, 16'h0100);
    host.wr(SEL_STD_EN, 16'h0001);
    operationIn.constVoltage = 1'b1;
    stdEventIn = 8'h01;
    tick(2);
    check("byte all", 16'(statusByte_q), 16'h00f8);
    rc("srq cond", SEL_SRQ_COND, 16'h00f8);
    rc("srq evt", SEL_SRQ_EVT, 16'h00f8);
    rc("srq level", SEL_SRQ_EVT, 16'h0000);
    rc("std evt", SEL_STD_EVT, 16'h0001);
    tick(2);
    check("byte std clr", 16'(statusByte_q), 16'h00d8);
    print_verdict();
  end

  initial begin
    #(40 * 4000);
    n_errors++;
    print_verdict();
  end
endmodule
